// [verilog/ret_rot_pkg.sv]
// constants and types for the return and rotate execution block
package ret_rot_pkg;
    localparam int DATA_W = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int PC_W = 15;
    localparam int GLOBAL_INT_ENABLE_BIT = 7;
    localparam logic [DATA_W-1:0] INTR_CTRL_SET_MASK =
        DATA_W'(1'h1) << GLOBAL_INT_ENABLE_BIT;
    localparam logic DEST_WORKING = 1'h0;
    localparam logic DEST_FILE = 1'h1;
    localparam int RETURN_CYCLES = 2;
    localparam int ROTATE_CYCLES = 1;

    typedef enum logic [2:0]
    {
        OP_NONE = 3'h0,
        OP_RETURN_FROM_INTERRUPT = 3'h1,
        OP_RETURN = 3'h2,
        OP_RETURN_WITH_LITERAL = 3'h3,
        OP_ROTATE_LEFT_CARRY = 3'h4
    } op_type;

    typedef enum logic
    {
        ST_IDLE = 1'h0,
        ST_FLUSH = 1'h1
    } state_type;
endpackage

// [verilog/rotate_left_carry.sv]
// one-bit left rotate through the carry flag
`timescale 1ns/1ps
module rotate_left_carry #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] operand,
    input wire logic carry_old,
    output logic [WIDTH-1:0] result,
    output logic carry_new
);
    always_comb
    begin
        result = {operand[WIDTH-2:0], carry_old};
        carry_new = operand[WIDTH-1];
    end
endmodule

// [verilog/return_and_rotate_instruction_exec.sv]
// execution of the return, return-with-literal and rotate-left instructions
`timescale 1ns/1ps
module return_and_rotate_instruction_exec #(
    parameter int DATA_W = ret_rot_pkg::DATA_W,
    parameter int FILE_ADDR_W = ret_rot_pkg::FILE_ADDR_W,
    parameter int PC_W = ret_rot_pkg::PC_W
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic issue_valid,
    input wire ret_rot_pkg::op_type issue_op,
    input wire logic [DATA_W-1:0] literal,
    input wire logic [FILE_ADDR_W-1:0] file_addr,
    input wire logic dest_sel,
    input wire logic [DATA_W-1:0] file_rdata,
    input wire logic carry_flag,
    input wire logic [PC_W-1:0] top_of_stack_entry,
    output logic busy,
    output logic done,
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    output logic working_write,
    output logic [DATA_W-1:0] working_value,
    output logic file_write,
    output logic [FILE_ADDR_W-1:0] file_waddr,
    output logic [DATA_W-1:0] file_wdata,
    output logic carry_write,
    output logic carry_value,
    output logic intr_ctrl_set,
    output logic [DATA_W-1:0] intr_ctrl_set_mask
);
    ret_rot_pkg::state_type state_q, state_d;
    logic done_q, done_d;
    logic pop_q, pop_d;
    logic [PC_W-1:0] pc_q, pc_d;
    logic wwr_q, wwr_d;
    logic [DATA_W-1:0] wval_q, wval_d;
    logic fwr_q, fwr_d;
    logic [FILE_ADDR_W-1:0] faddr_q, faddr_d;
    logic [DATA_W-1:0] fdata_q, fdata_d;
    logic cwr_q, cwr_d;
    logic cval_q, cval_d;
    logic ien_q, ien_d;
    logic busy_q, busy_d;
    logic [DATA_W-1:0] mask_q, mask_d;
    logic take;
    logic [DATA_W-1:0] rot_result;
    logic rot_carry;

    // a new instruction is refused while the second return cycle runs
    assign take = issue_valid && (state_q == ret_rot_pkg::ST_IDLE);

    rotate_left_carry #(
        .WIDTH(DATA_W)
    ) u_rotate (
        .operand(file_rdata),
        .carry_old(carry_flag),
        .result(rot_result),
        .carry_new(rot_carry)
    );

    always_comb
    begin
        state_d = ret_rot_pkg::ST_IDLE;
        done_d = 1'h0;
        pop_d = 1'h0;
        pc_d = pc_q;
        wwr_d = 1'h0;
        wval_d = wval_q;
        fwr_d = 1'h0;
        faddr_d = faddr_q;
        fdata_d = fdata_q;
        cwr_d = 1'h0;
        cval_d = cval_q;
        ien_d = 1'h0;
        mask_d = DATA_W'(ret_rot_pkg::INTR_CTRL_SET_MASK);
        unique case (state_q)
            ret_rot_pkg::ST_IDLE:
            begin
                if (take)
                begin
                    unique case (issue_op)
                        ret_rot_pkg::OP_RETURN_FROM_INTERRUPT:
                        begin
                            state_d = ret_rot_pkg::ST_FLUSH;
                            pop_d = 1'h1;
                            pc_d = top_of_stack_entry;
                            ien_d = 1'h1;
                        end
                        ret_rot_pkg::OP_RETURN:
                        begin
                            state_d = ret_rot_pkg::ST_FLUSH;
                            pop_d = 1'h1;
                            pc_d = top_of_stack_entry;
                        end
                        ret_rot_pkg::OP_RETURN_WITH_LITERAL:
                        begin
                            state_d = ret_rot_pkg::ST_FLUSH;
                            pop_d = 1'h1;
                            pc_d = top_of_stack_entry;
                            wwr_d = 1'h1;
                            wval_d = literal;
                        end
                        ret_rot_pkg::OP_ROTATE_LEFT_CARRY:
                        begin
                            done_d = 1'h1;
                            cwr_d = 1'h1;
                            cval_d = rot_carry;
                            if (dest_sel == ret_rot_pkg::DEST_FILE)
                            begin
                                fwr_d = 1'h1;
                                faddr_d = file_addr;
                                fdata_d = rot_result;
                            end
                            else
                            begin
                                wwr_d = 1'h1;
                                wval_d = rot_result;
                            end
                        end
                        // unknown codes retire at once with no effect
                        default:
                        begin
                            done_d = 1'h1;
                        end
                    endcase
                end
            end
            ret_rot_pkg::ST_FLUSH:
            begin
                // second cycle: fetched word is discarded, nothing written
                done_d = 1'h1;
            end
        endcase
        busy_d = (state_d == ret_rot_pkg::ST_FLUSH);
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            state_q <= ret_rot_pkg::ST_IDLE;
            done_q <= 1'h0;
            pop_q <= 1'h0;
            pc_q <= '0;
            wwr_q <= 1'h0;
            wval_q <= '0;
            fwr_q <= 1'h0;
            faddr_q <= '0;
            fdata_q <= '0;
            cwr_q <= 1'h0;
            cval_q <= 1'h0;
            ien_q <= 1'h0;
            busy_q <= 1'h0;
            mask_q <= DATA_W'(ret_rot_pkg::INTR_CTRL_SET_MASK);
        end
        else
        begin
            state_q <= state_d;
            done_q <= done_d;
            pop_q <= pop_d;
            pc_q <= pc_d;
            wwr_q <= wwr_d;
            wval_q <= wval_d;
            fwr_q <= fwr_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
            cwr_q <= cwr_d;
            cval_q <= cval_d;
            ien_q <= ien_d;
            busy_q <= busy_d;
            mask_q <= mask_d;
        end
    end

    assign busy = busy_q;
    assign done = done_q;
    assign stack_pop = pop_q;
    assign pc_load = pop_q;
    assign pc_value = pc_q;
    assign working_write = wwr_q;
    assign working_value = wval_q;
    assign file_write = fwr_q;
    assign file_waddr = faddr_q;
    assign file_wdata = fdata_q;
    assign carry_write = cwr_q;
    assign carry_value = cval_q;
    assign intr_ctrl_set = ien_q;
    // mask is fixed but registered so every output leaves a flop
    assign intr_ctrl_set_mask = mask_q;

    AST_INTR_RETURN_POP_ENABLE: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_RETURN_FROM_INTERRUPT) |=>
        (stack_pop && pc_load && intr_ctrl_set
        && pc_value == $past(top_of_stack_entry)
        && intr_ctrl_set_mask[ret_rot_pkg::GLOBAL_INT_ENABLE_BIT]))
        else $error("interrupt return did not pop, load pc and enable");

    AST_RETURN_TWO_CYCLES: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && (issue_op == ret_rot_pkg::OP_RETURN_FROM_INTERRUPT
        || issue_op == ret_rot_pkg::OP_RETURN
        || issue_op == ret_rot_pkg::OP_RETURN_WITH_LITERAL)) |=>
        (busy && !done && !carry_write) ##1 (!busy && done && !carry_write))
        else $error("return did not take exactly two cycles");

    AST_RETURN_PLAIN: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_RETURN) |=>
        (stack_pop && pc_value == $past(top_of_stack_entry)
        && !intr_ctrl_set && !working_write && !file_write))
        else $error("subroutine return wrong effects");

    AST_LITERAL_RETURN_WORKING: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_RETURN_WITH_LITERAL) |=>
        (working_write && working_value == $past(literal)))
        else $error("literal not written to working register");

    AST_LITERAL_RETURN_POP: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_RETURN_WITH_LITERAL) |=>
        (stack_pop && pc_load && pc_value == $past(top_of_stack_entry)
        && !intr_ctrl_set) ##1 (done && !stack_pop))
        else $error("literal return did not pop in two cycles");

    AST_ROTATE_RESULT: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY) |=>
        (done && !busy && carry_write
        && carry_value == $past(file_rdata[DATA_W-1])
        && (working_write ? working_value : file_wdata)
        == {$past(file_rdata[DATA_W-2:0]), $past(carry_flag)}))
        else $error("rotate result or carry wrong");

    AST_ROTATE_DEST: assert property (@(posedge sys_clk)
        disable iff (reset)
        (take && issue_op == ret_rot_pkg::OP_ROTATE_LEFT_CARRY) |=>
        ($past(dest_sel) ? (file_write && !working_write
        && file_waddr == $past(file_addr))
        : (working_write && !file_write)))
        else $error("rotate destination wrong");

    AST_ONE_POP_PER_RETURN: assert property (@(posedge sys_clk)
        disable iff (reset)
        stack_pop |=> !stack_pop)
        else $error("stack popped twice for one return");
endmodule

// [testbench/test_return_and_rotate_instruction_exec.sv]
// self-checking bench for the return and rotate execution block
`timescale 1ns/1ps
module test_return_and_rotate_instruction_exec;
    logic sys_clk = 1'h0;
    logic reset = 1'h1;
    logic issue_valid = 1'h0;
    ret_rot_pkg::op_type issue_op = ret_rot_pkg::OP_NONE;
    logic [7:0] literal = 8'h00;
    logic [6:0] file_addr = 7'h00;
    logic dest_sel = 1'h0;
    logic [7:0] file_rdata = 8'h00;
    logic carry_flag = 1'h0;
    logic [14:0] top_of_stack_entry = 15'h0000;
    logic busy, done, stack_pop, pc_load, working_write, file_write;
    logic carry_write, carry_value, intr_ctrl_set;
    logic [14:0] pc_value;
    logic [7:0] working_value, file_wdata, intr_ctrl_set_mask;
    logic [6:0] file_waddr;
    int mismatches = 0;
    int n_checks = 0;

    return_and_rotate_instruction_exec uut (
        .sys_clk(sys_clk), .reset(reset), .issue_valid(issue_valid),
        .issue_op(issue_op), .literal(literal), .file_addr(file_addr),
        .dest_sel(dest_sel), .file_rdata(file_rdata),
        .carry_flag(carry_flag), .top_of_stack_entry(top_of_stack_entry),
        .busy(busy), .done(done), .stack_pop(stack_pop), .pc_load(pc_load),
        .pc_value(pc_value), .working_write(working_write),
        .working_value(working_value), .file_write(file_write),
        .file_waddr(file_waddr), .file_wdata(file_wdata),
        .carry_write(carry_write), .carry_value(carry_value),
        .intr_ctrl_set(intr_ctrl_set),
        .intr_ctrl_set_mask(intr_ctrl_set_mask)
    );

    initial
    begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    task chk(input string name, input logic [15:0] seen,
        input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // inputs move 1 ns after the edge, outputs are read at the same point
    task step;
        @(posedge sys_clk);
        #1;
    endtask

    // back to back rotates, destinations alternating, bit 7 and bit 0 corners
    task test_rotate;
        logic [7:0] v [4] = '{8'hE6, 8'h01, 8'h80, 8'h7F};
        logic [7:0] r;
        for (int i = 0; i < 4; i++)
        begin
            issue_op = ret_rot_pkg::OP_ROTATE_LEFT_CARRY;
            file_rdata = v[i];
            carry_flag = i[0];
            dest_sel = i[0];
            file_addr = 7'(i * 42);
            issue_valid = 1'h1;
            step;
            r = {v[i][6:0], carry_flag};
            chk("rot_done", 16'(done), 16'h1);
            chk("rot_cw", 16'(carry_write), 16'h1);
            chk("rot_cv", 16'(carry_value), 16'(v[i][7]));
            chk("rot_busy", 16'({busy, stack_pop}), 16'h0);
            chk("rot_fw", 16'(file_write), 16'(dest_sel));
            chk("rot_ww", 16'(working_write), 16'(!dest_sel));
            if (dest_sel)
            begin
                chk("rot_fa", 16'(file_waddr), 16'(file_addr));
                chk("rot_fd", 16'(file_wdata), 16'(r));
            end
            else
                chk("rot_w", 16'(working_value), 16'(r));
        end
        issue_valid = 1'h0;
        step;
        chk("rot_idle", 16'({done, carry_write, file_write}), 16'h0);
    endtask

    // a return, with a rotate offered while busy that must be ignored
    task test_return(input ret_rot_pkg::op_type op, input logic [7:0] k,
        input logic [14:0] ret_addr);
        logic is_intr;
        logic is_lit;
        is_intr = (op == ret_rot_pkg::OP_RETURN_FROM_INTERRUPT);
        is_lit = (op == ret_rot_pkg::OP_RETURN_WITH_LITERAL);
        issue_op = op;
        literal = k;
        top_of_stack_entry = ret_addr;
        issue_valid = 1'h1;
        step;
        issue_op = ret_rot_pkg::OP_ROTATE_LEFT_CARRY;
        literal = ~k;
        top_of_stack_entry = ~ret_addr;
        chk("ret_busy", 16'({busy, done}), 16'h2);
        chk("ret_pop", 16'({stack_pop, pc_load}), 16'h3);
        chk("ret_pc", 16'(pc_value), 16'(ret_addr));
        chk("ret_ien", 16'(intr_ctrl_set), 16'(is_intr));
        chk("ret_mask", 16'(intr_ctrl_set_mask), 16'h0080);
        chk("ret_ww", 16'(working_write), 16'(is_lit));
        if (is_lit)
            chk("ret_w", 16'(working_value), 16'(k));
        chk("ret_flags", 16'({carry_write, file_write}), 16'h0);
        step;
        issue_valid = 1'h0;
        chk("ret_done", 16'({busy, done}), 16'h1);
        chk("ret_nopop", 16'({stack_pop, carry_write}), 16'h0);
        chk("ret_nowr", 16'({file_write, working_write}), 16'h0);
        chk("ret_noien", 16'(intr_ctrl_set), 16'h0);
        step;
        chk("ret_end", 16'({busy, done, carry_write}), 16'h0);
    endtask

    // reset in the middle of a return clears every pulse and busy
    task test_reset;
        issue_op = ret_rot_pkg::OP_RETURN_FROM_INTERRUPT;
        issue_valid = 1'h1;
        step;
        issue_valid = 1'h0;
        reset = 1'h1;
        step;
        reset = 1'h0;
        chk("rst_busy", 16'({busy, done, stack_pop, pc_load}), 16'h0);
        chk("rst_ien", 16'(intr_ctrl_set), 16'h0);
        chk("rst_pc", 16'(pc_value), 16'h0000);
        chk("rst_mask", 16'(intr_ctrl_set_mask), 16'h0080);
        step;
        chk("rst_idle", 16'({busy, done}), 16'h0);
    endtask

    // codes outside the decoded set retire at once with no effect
    task test_unknown(input logic [2:0] code);
        issue_op = ret_rot_pkg::op_type'(code);
        issue_valid = 1'h1;
        step;
        issue_valid = 1'h0;
        chk("unk_done", 16'({busy, done}), 16'h1);
        chk("unk_pop", 16'({stack_pop, carry_write}), 16'h0);
        chk("unk_wr", 16'({file_write, working_write}), 16'h0);
        chk("unk_ien", 16'(intr_ctrl_set), 16'h0);
        step;
        chk("unk_end", 16'({busy, done}), 16'h0);
    endtask

    initial
    begin
        #20000;
        mismatches++;
        summarize;
    end

    initial
    begin
        repeat (20) @(posedge sys_clk);
        #1;
        reset = 1'h0;
        chk("init_mask", 16'(intr_ctrl_set_mask), 16'h0080);
        test_rotate;
        test_return(ret_rot_pkg::OP_RETURN_FROM_INTERRUPT, 8'h5A, 15'h7FFF);
        test_return(ret_rot_pkg::OP_RETURN, 8'h33, 15'h0001);
        test_return(ret_rot_pkg::OP_RETURN_WITH_LITERAL, 8'hFF, 15'h2AAA);
        test_return(ret_rot_pkg::OP_RETURN_WITH_LITERAL, 8'h00, 15'h5555);
        test_unknown(3'h0);
        test_unknown(3'h5);
        test_reset;
        test_rotate;
        summarize;
    end
endmodule
